// File: common/rtctw_pkg.sv
// constants and types of the two-wire slave port of the clock/calendar
// How it works
// - slave only; never drives the clock
// - bytes shift most significant bit first
// - data line changes only while clock low
// - data line released after power-up
// - start is data falling, clock high
// - starts during power-up are ignored
// - stop returns the port to standby
// - receiver pulls data low on ninth clock
// - acknowledge slave and register address bytes
// - acknowledge every written data byte
// - identifier bits must be 1101000
// - direction bit one reads, zero writes
// - compare identifier after full byte, ack on match
// - second byte loads the register pointer
// - pointer is zero after power-up
// - write is address, register, data, stop
// - random read uses dummy write, repeated start
// - send bytes while master keeps acknowledging
// - read pointer advances once per byte sent
// - read pointer rolls over 1Fh to 00h
// - write pointer wraps 07h to 00h
// - snapshot time registers when read begins
// - pointer left one past last access
package rtctw_pkg;

  localparam logic [6:0] SLAVE_ID = 7'h68;
  localparam logic [4:0] PTR_RESET = 5'h00;
  localparam logic [4:0] REG_LAST = 5'h07;
  localparam int REG_COUNT = 8;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef logic [REG_COUNT-1:0][7:0] rtctw_bank_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } rtctw_wr_t;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_REG = 10'h004,
    ST_WR = 10'h008,
    ST_ACK = 10'h010,
    ST_RD = 10'h020,
    ST_RDACK = 10'h040,
    ST_RDGO = 10'h080,
    ST_IGNORE = 10'h100,
    ST_SPARE = 10'h200
  } rtctw_state_t;

endpackage : rtctw_pkg

// File: hw/rtctw_slave.sv
// two-wire slave port: framing, address match, pointer, register bank access
`timescale 1ns/10ps
`default_nettype none
module rtctw_slave
  import rtctw_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic clk_scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire rtctw_bank_t regs_i,
  output logic wr_en_o,
  output var rtctw_wr_t wr_o
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain: each rising serial clock captures one data bit and flips a
  // toggle; the bit stays stable for a whole serial period, far longer than
  // the toggle needs to cross, so it is read directly once the toggle lands

  logic sda_bit_ff;
  logic tog_ff;

  always_ff @(posedge clk_scl_i) begin
    if (!nrst_i) begin
      sda_bit_ff <= 1'b1;
      tog_ff <= 1'b0;
    end else begin
      sda_bit_ff <= sda_i;
      tog_ff <= ~tog_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system domain synchronisers; third stage only feeds edge detection

  logic scl_m_ff, scl_s_ff, scl_d_ff;
  logic sda_m_ff, sda_s_ff, sda_d_ff;
  logic tog_m_ff, tog_s_ff, tog_d_ff;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
      {tog_m_ff, tog_s_ff, tog_d_ff} <= 3'h0;
    end else begin
      scl_m_ff <= clk_scl_i;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_i;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
      tog_m_ff <= tog_ff;
      tog_s_ff <= tog_m_ff;
      tog_d_ff <= tog_s_ff;
    end
  end

  logic start_ev, stop_ev, scl_fall, bit_ev;

  assign start_ev = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign stop_ev = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  assign scl_fall = scl_d_ff & ~scl_s_ff;
  assign bit_ev = (tog_s_ff != tog_d_ff);

  ////////////////////////////////////////////////////////////////////////////
  // power-up window

  localparam int PW_W = $clog2(PWRUP_CYC + 1);
  logic [PW_W-1:0] pwr_cnt_ff;
  logic pwr_busy;

  assign pwr_busy = (pwr_cnt_ff != '0);

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pwr_cnt_ff <= PW_W'(PWRUP_CYC);
    end else if (pwr_busy) begin
      pwr_cnt_ff <= pwr_cnt_ff - PW_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // protocol engine

  rtctw_state_t st_ff, after_ff;
  logic [2:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] tx_ff;
  logic ack_drv_ff;
  logic done8_ff;
  logic oe_ff;
  logic [4:0] ptr_ff;
  logic [7:0] hold_ff [REG_COUNT];
  logic [7:0] byte_in;
  logic byte_done;
  logic [7:0] hold_byte;

  assign byte_in = {sh_ff[6:0], sda_bit_ff};
  assign byte_done = bit_ev & (cnt_ff == 3'h7);
  // nothing lives above the last register, so those addresses read zero
  assign hold_byte = (ptr_ff <= REG_LAST) ? hold_ff[ptr_ff[2:0]] : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        hold_ff[i] <= 8'h00;
      end
    end else if (st_ff == ST_ADDR && byte_done && byte_in[7:1] == SLAVE_ID && byte_in[0]) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        hold_ff[i] <= regs_i[i];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_ff <= ST_IDLE;
      after_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
      sh_ff <= 8'h00;
      tx_ff <= 8'h00;
      ack_drv_ff <= 1'b0;
      done8_ff <= 1'b0;
      oe_ff <= 1'b0;
      ptr_ff <= PTR_RESET;
      wr_en_o <= 1'b0;
      wr_o <= '0;
    end else begin
      wr_en_o <= 1'b0;
      if (start_ev && !pwr_busy) begin
        // a repeated start also lands here, mid-transfer
        st_ff <= ST_ADDR;
        cnt_ff <= 3'h0;
        ack_drv_ff <= 1'b0;
        done8_ff <= 1'b0;
        oe_ff <= 1'b0;
      end else if (start_ev || stop_ev) begin
        st_ff <= ST_IDLE;
        oe_ff <= 1'b0;
        ack_drv_ff <= 1'b0;
      end else begin
        case (st_ff)
          ST_ADDR, ST_REG, ST_WR: begin
            if (bit_ev) begin
              sh_ff <= byte_in;
              cnt_ff <= 3'(cnt_ff + 3'h1);
            end
            if (byte_done) begin
              st_ff <= ST_ACK;
              if (st_ff == ST_ADDR) begin
                // identifier checked only once all eight bits are in
                if (byte_in[7:1] != SLAVE_ID) begin
                  st_ff <= ST_IGNORE;
                end else if (byte_in[0]) begin
                  after_ff <= ST_RD;
                  tx_ff <= (ptr_ff <= REG_LAST) ? regs_i[ptr_ff[2:0]] : 8'h00;
                  ptr_ff <= 5'(ptr_ff + 5'h01);
                end else begin
                  after_ff <= ST_REG;
                end
              end else if (st_ff == ST_REG) begin
                ptr_ff <= byte_in[4:0];
                after_ff <= ST_WR;
              end else begin
                if (ptr_ff <= REG_LAST) begin
                  wr_en_o <= 1'b1;
                end
                wr_o <= '{addr: ptr_ff, data: byte_in};
                // writes only span the real registers
                ptr_ff <= (ptr_ff >= REG_LAST) ? PTR_RESET : 5'(ptr_ff + 5'h01);
                after_ff <= ST_WR;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (!ack_drv_ff) begin
                oe_ff <= 1'b1;
                ack_drv_ff <= 1'b1;
              end else begin
                ack_drv_ff <= 1'b0;
                st_ff <= after_ff;
                cnt_ff <= 3'h0;
                done8_ff <= 1'b0;
                oe_ff <= (after_ff == ST_RD) ? ~tx_ff[7] : 1'b0;
              end
            end
          end
          ST_RD: begin
            if (bit_ev) begin
              cnt_ff <= 3'(cnt_ff + 3'h1);
              if (cnt_ff == 3'h7) begin
                done8_ff <= 1'b1;
              end
            end
            if (scl_fall) begin
              if (done8_ff) begin
                oe_ff <= 1'b0;
                done8_ff <= 1'b0;
                st_ff <= ST_RDACK;
              end else begin
                tx_ff <= {tx_ff[6:0], 1'b0};
                oe_ff <= ~tx_ff[6];
              end
            end
          end
          ST_RDACK: begin
            if (bit_ev) begin
              if (!sda_bit_ff) begin
                st_ff <= ST_RDGO;
                tx_ff <= hold_byte;
                ptr_ff <= 5'(ptr_ff + 5'h01);
              end else begin
                st_ff <= ST_IGNORE;
              end
            end
          end
          ST_RDGO: begin
            if (scl_fall) begin
              st_ff <= ST_RD;
              cnt_ff <= 3'h0;
              oe_ff <= ~tx_ff[7];
            end
          end
          ST_IDLE, ST_IGNORE: begin
            oe_ff <= 1'b0;
          end
          default: begin
            st_ff <= ST_IDLE;
            oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: open drain, the clock line is never driven at all

  logic sda_zero_ff;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      sda_zero_ff <= 1'b0;
    end else begin
      sda_zero_ff <= 1'b0;
    end
  end

  assign sda_o = sda_zero_ff;
  assign sda_oe_o = oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic first_ff;

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  idle_released_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_IDLE) |=> !sda_oe_o || (st_ff != ST_IDLE))
    else $error("data line driven while idle");

  ignore_released_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_IGNORE) |-> ##1 (!sda_oe_o || st_ff != ST_IGNORE))
    else $error("data line driven after address mismatch");

  drive_low_clk_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    $changed(oe_ff) |-> !$past(scl_s_ff) || $past(start_ev | stop_ev))
    else $error("data drive changed while clock high");

  pwrup_start_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (start_ev && pwr_busy) |=> (st_ff == ST_IDLE))
    else $error("start accepted during power-up");

  stop_idle_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (stop_ev && !start_ev) |=> (st_ff == ST_IDLE) && !oe_ff)
    else $error("stop did not return to standby");

  restart_addr_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (start_ev && !pwr_busy) |=> (st_ff == ST_ADDR) && (cnt_ff == 3'h0))
    else $error("start did not restart address reception");

  mismatch_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_ADDR && byte_done && !start_ev && !stop_ev
     && byte_in[7:1] != SLAVE_ID) |=> (st_ff == ST_IGNORE))
    else $error("mismatched identifier was acknowledged");

  wr_wrap_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (wr_en_o && wr_o.addr == REG_LAST) |-> (ptr_ff == PTR_RESET))
    else $error("write pointer did not wrap to zero");

  wr_range_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    wr_en_o |-> (wr_o.addr <= REG_LAST) && (ptr_ff != wr_o.addr))
    else $error("write strobe out of range or pointer not advanced");

  rd_advance_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_RDACK && bit_ev && !sda_bit_ff && !start_ev && !stop_ev)
    |=> (ptr_ff == 5'($past(ptr_ff) + 5'h01)) && (st_ff == ST_RDGO))
    else $error("read pointer did not advance by one");

  pwrup_ptr_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    first_ff |-> (ptr_ff == PTR_RESET))
    else $error("pointer not zero after power-up");

  ack_hold_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_ACK && scl_fall && !ack_drv_ff && !start_ev && !stop_ev)
    |=> oe_ff && ack_drv_ff)
    else $error("acknowledge not driven on ninth clock");

  sda_low_only_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (sda_o == 1'b0))
    else $error("data line driven to a high level");

  oe_after_reset_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    first_ff |-> !sda_oe_o)
    else $error("data line driven right after reset");

  id_match_ack_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_ADDR && byte_done && !start_ev && !stop_ev
     && byte_in[7:1] == SLAVE_ID) |=> (st_ff == ST_ACK))
    else $error("matching identifier not acknowledged");

  dir_read_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_ADDR && byte_done && !start_ev && !stop_ev
     && byte_in[7:1] == SLAVE_ID && byte_in[0]) |=> (after_ff == ST_RD))
    else $error("read direction bit not honoured");

  reg_load_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_REG && byte_done && !start_ev && !stop_ev)
    |=> (ptr_ff == $past(byte_in[4:0])))
    else $error("register byte not loaded into pointer");

  data_ack_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_WR && byte_done && !start_ev && !stop_ev) |=> (st_ff == ST_ACK))
    else $error("written data byte not acknowledged");

  rd_roll_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_RDACK && bit_ev && !sda_bit_ff && !start_ev && !stop_ev
     && ptr_ff == '1) |=> (ptr_ff == PTR_RESET))
    else $error("read pointer did not roll over to zero");

  nack_end_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_RDACK && bit_ev && sda_bit_ff && !start_ev && !stop_ev)
    |=> (st_ff == ST_IGNORE))
    else $error("read went on after master refusal");

  rd_release_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_RD && scl_fall && done8_ff && !start_ev && !stop_ev) |=> !oe_ff)
    else $error("data line not released after eighth read bit");

  hold_stable_a: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_RD || st_ff == ST_RDACK || st_ff == ST_RDGO)
    |=> $stable(hold_ff[0]) && $stable(hold_ff[REG_COUNT-1]))
    else $error("read snapshot changed during a read");

  write_seen_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) wr_en_o);
  read_more_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_RDGO));
  mismatch_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_IGNORE));
  restart_c: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
    (st_ff == ST_REG || st_ff == ST_WR) && start_ev);

endmodule : rtctw_slave
`default_nettype wire

// File: bench/rtctw_master_model.sv
// behavioural two-wire bus master that drives the serial clock and data line
`timescale 1ns/10ps
`default_nettype none
module rtctw_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  localparam realtime HALF = 62.5;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // scl idles high between frames; data moves only while scl is low, except for the start and stop edges
  task automatic pulse();
    #HALF scl_o = 1'b0;
    #HALF scl_o = 1'b1;
  endtask : pulse
  task automatic start_cond();
    sda_o = 1'b1;
    #HALF scl_o = 1'b1;
    #HALF sda_o = 1'b0;
    #HALF scl_o = 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    sda_o = 1'b0;
    #HALF scl_o = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask : stop_cond
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      #HALF scl_o = 1'b1;
      #HALF scl_o = 1'b0;
    end
    sda_o = 1'b1;
    #HALF scl_o = 1'b1;
    ack = ~sda_i;
    #HALF scl_o = 1'b0;
  endtask : put_byte
  task automatic get_byte(input logic more, output logic [7:0] b);
    sda_o = 1'b1;
    for (int i = 0; i < 8; i++) begin
      #HALF scl_o = 1'b1;
      b = {b[6:0], sda_i};
      #HALF scl_o = 1'b0;
    end
    sda_o = ~more;
    #HALF scl_o = 1'b1;
    #HALF scl_o = 1'b0;
    sda_o = 1'b1;
  endtask : get_byte
endmodule : rtctw_master_model
`default_nettype wire

// File: bench/test_rtc_two_wire_slave_port.sv
// self-checking bench of the two-wire slave port against a pointer and bank model
`timescale 1ns/10ps
`default_nettype none
module test_rtc_two_wire_slave_port;
  import rtctw_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe_o;
  logic wr_en_o;
  logic ack;
  logic [7:0] rb;
  logic [7:0] mb [8];
  rtctw_bank_t regs_i = '0;
  rtctw_wr_t wr_o;
  rtctw_wr_t wq[$];
  int num_errors = 0;
  int num_checks = 0;
  int ptr = 0;
  // open-drain wire with pull-up
  wire logic sda_i = sda_m & ~sda_oe_o;
  always #5 clk_sys_i = ~clk_sys_i;
  rtctw_slave i_rtctw_slave (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .clk_scl_i(scl),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .regs_i(regs_i), .wr_en_o(wr_en_o),
    .wr_o(wr_o));
  rtctw_master_model i_rtctw_master_model (.sda_i(sda_i), .scl_o(scl), .sda_o(sda_m));
  always @(posedge clk_sys_i) begin
    if (wr_en_o) begin
      wq.push_back(wr_o);
    end
  end
  always @(sda_oe_o) begin
    if (nrst_i) check(16'(scl), 16'h0000);
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic send(input logic [7:0] b, input logic exp_ack);
    i_rtctw_master_model.put_byte(b, ack);
    check(16'(ack), 16'(exp_ack));
  endtask : send
  task automatic wr_seq(input logic [7:0] r, input int n);
    logic [7:0] d;
    i_rtctw_master_model.start_cond();
    send(8'hD0, 1'b1);
    send(r, 1'b1);
    ptr = int'(r[4:0]);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      send(d, 1'b1);
      check(16'(wq.size()), 16'(ptr < 8));
      if (ptr < 8 && wq.size() > 0) begin
        check(16'(wq.pop_front()), 16'({5'(ptr), d}));
        mb[ptr] = d;
        regs_i[ptr] = d;
      end
      ptr = (ptr >= 7) ? 0 : ptr + 1;
    end
    i_rtctw_master_model.stop_cond();
    wq.delete();
  endtask : wr_seq
  task automatic rd_seq(input int n);
    logic [7:0] snap [8];
    snap = mb;
    i_rtctw_master_model.start_cond();
    send(8'hD1, 1'b1);
    // time registers move on mid-read; the returned bytes must not
    @(negedge clk_sys_i);
    regs_i = {$urandom, $urandom};
    for (int i = 0; i < n; i++) begin
      i_rtctw_master_model.get_byte(i < n - 1, rb);
      check(16'(rb), 16'(ptr < 8 ? snap[ptr] : 8'h00));
      ptr = (ptr + 1) % 32;
    end
    i_rtctw_master_model.stop_cond();
    for (int i = 0; i < 8; i++) regs_i[i] = mb[i];
  endtask : rd_seq
  task automatic rr(input logic [7:0] r, input int n);
    i_rtctw_master_model.start_cond();
    send(8'hD0, 1'b1);
    send(r, 1'b1);
    ptr = int'(r[4:0]);
    rd_seq(n);
  endtask : rr
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0D42));
    for (int i = 0; i < 8; i++) begin
      mb[i] = 8'($urandom);
      regs_i[i] = mb[i];
    end
    repeat (3) @(negedge clk_sys_i);
    i_rtctw_master_model.pulse();
    i_rtctw_master_model.pulse();
    check(16'(sda_oe_o), 16'h0000);
    check(16'(sda_o), 16'h0000);
    @(negedge clk_sys_i);
    nrst_i = 1'b1;
    repeat (10) @(negedge clk_sys_i);
    i_rtctw_master_model.start_cond();
    send(8'hD0, 1'b0);
    i_rtctw_master_model.stop_cond();
    repeat (150) @(negedge clk_sys_i);
    $display("test powerup done");
    rd_seq(1);
    wr_seq(8'h06, 3);
    rd_seq(2);
    $display("test write wrap done");
    rr(8'h1E, 4);
    $display("test read rollover done");
    i_rtctw_master_model.start_cond();
    send({7'h68 ^ 7'(1 << ($urandom % 7)), 1'b0}, 1'b0);
    send(8'h00, 1'b0);
    i_rtctw_master_model.stop_cond();
    check(16'(wq.size()), 16'h0000);
    wr_seq(8'h0A, 1);
    rd_seq(1);
    $display("test refusals done");
    repeat (6) begin
      if ($urandom % 2) wr_seq(8'($urandom % 8), 1 + $urandom % 3);
      else rr(8'($urandom % 8), 1 + $urandom % 3);
    end
    $display("test random done");
    tally_and_finish();
  end
  initial begin
    #800us;
    num_errors++;
    tally_and_finish();
  end
endmodule : test_rtc_two_wire_slave_port
`default_nettype wire
